// ==== smbtp_map.svh ====
// smbtp_map.svh: numeric constants of the two-wire register target port
// assumes: included by bare name by the target module only
`ifndef SMBTP_MAP_SVH
`define SMBTP_MAP_SVH

// target address (upper seven bits of the first byte)
`define SMBTP_TARGET_ADDR 7'h28
// bits per byte and the count that marks a whole byte
`define SMBTP_BYTE_BITS 8
`define SMBTP_BIT_CNT_FULL 4'h8
`define SMBTP_BIT_CNT_ONE 4'h1
`define SMBTP_BIT_CNT_ZERO 4'h0
// pointer reset value and increment
`define SMBTP_PTR_RESET 8'h00
`define SMBTP_PTR_STEP 8'h01
// system clock rate
`define SMBTP_CLK_KHZ 25000
// clock-low timeout and bus-idle reset times
`define SMBTP_SCL_LOW_MS 30
`define SMBTP_IDLE_US 400
`define SMBTP_SCL_LOW_CYCLES (`SMBTP_SCL_LOW_MS * `SMBTP_CLK_KHZ)
`define SMBTP_IDLE_CYCLES ((`SMBTP_IDLE_US * `SMBTP_CLK_KHZ) / 1000)

`endif

// ==== smbtp_pkg.sv ====
// smbtp_pkg.sv: types shared by the two-wire register target port
// assumes: constants come from smbtp_map.svh
package smbtp_pkg;

    // target protocol states
    typedef enum logic [2:0] {
        SMBTP_IDLE,
        SMBTP_ADDR,
        SMBTP_ADDR_ACK,
        SMBTP_RX,
        SMBTP_RX_ACK,
        SMBTP_TX,
        SMBTP_TX_ACK,
        SMBTP_IGNORE
    } smbtp_state_t;

    // access to the register space behind the port
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smbtp_reg_req_t;

    // open-drain data pin drive
    typedef struct packed {
        logic out;
        logic oe_n;
    } smbtp_pin_drv_t;

endpackage

// ==== smbtp_sync.sv ====
// smbtp_sync.sv: three-flop synchroniser with agreement filter
// assumes: input is asynchronous to clk; output moves once stages 2 and 3 agree
`timescale 1ns/100ps
module smbtp_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // level
    input wire logic async_in,
    output logic level_out
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
        end else if (ce) begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // filter: a single-sample glitch on stage 2 never reaches the output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= RESET_VAL;
        end else if (ce && (s2_ff == s3_ff)) begin
            level_out <= s3_ff;
        end
    end

endmodule

// ==== smbtp_hold_timer.sv ====
// smbtp_hold_timer.sv: counts cycles while a condition holds
// assumes: run from the same clock; expired stays high while run stays high
`timescale 1ns/100ps
module smbtp_hold_timer #(
    parameter int CYCLES = 16,
    parameter int W = $clog2(CYCLES + 1)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // condition and result
    input wire logic run,
    output logic expired
);

    logic [W-1:0] cnt_ff;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            expired <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_ff <= '0;
                expired <= 1'b0;
            end else if (cnt_ff >= W'(CYCLES - 1)) begin
                expired <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + W'(1);
            end
        end
    end

endmodule

// ==== smbtp_target.sv ====
// smbtp_target.sv: two-wire serial target giving byte access to a register space
// assumes: register space answers reg_rdata combinationally for reg_req.addr;
//          bus pins are asynchronous and sampled by clk; an outside pull-up holds sda
`timescale 1ns/100ps
`include "smbtp_map.svh"
module smbtp_target #(
    parameter int SCL_LOW_CYCLES = `SMBTP_SCL_LOW_CYCLES,
    parameter int IDLE_CYCLES = `SMBTP_IDLE_CYCLES
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // bus pins
    input wire logic bus_clock_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // configuration and status
    input wire logic timeout_en,
    output logic busy,
    output logic timeout_hit,
    // register space
    output smbtp_pkg::smbtp_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import smbtp_pkg::*;

    logic rst_s1_ff;
    logic rst_s2_ff;
    logic rst_i;
    logic scl_f;
    logic sda_f;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic scl_low_tmo;
    logic idle_tmo;
    logic tmo_any;
    smbtp_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic rw_ff;
    logic idx_done_ff;
    logic wrote_ff;
    smbtp_pin_drv_t drv_ff;
    smbtp_reg_req_t req_ff;
    logic busy_ff;
    logic timeout_hit_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    assign rst_i = rst_s2_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling; idle bus level is high
    smbtp_sync #(
        .RESET_VAL(1'b1)
    ) u_scl_sync (
        .clk(clk),
        .rst_n(rst_i),
        .ce(ce),
        .async_in(bus_clock_pin),
        .level_out(scl_f)
    );

    smbtp_sync #(
        .RESET_VAL(1'b1)
    ) u_sda_sync (
        .clk(clk),
        .rst_n(rst_i),
        .ce(ce),
        .async_in(sda_in),
        .level_out(sda_f)
    );

    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else if (ce) begin
            scl_d_ff <= scl_f;
            sda_d_ff <= sda_f;
        end
    end

    // edges only; a held-low clock just waits
    assign scl_rise = scl_f & ~scl_d_ff;
    assign scl_fall = ~scl_f & scl_d_ff;
    assign start_det = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
    assign stop_det = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

    ////////////////////////////////////////////////////////////////////////////////
    // bus watchdogs
    // clock-low timeout
    smbtp_hold_timer #(
        .CYCLES(SCL_LOW_CYCLES)
    ) u_scl_low_timer (
        .clk(clk),
        .rst_n(rst_i),
        .ce(ce),
        .run(timeout_en & ~scl_f),
        .expired(scl_low_tmo)
    );

    smbtp_hold_timer #(
        .CYCLES(IDLE_CYCLES)
    ) u_idle_timer (
        .clk(clk),
        .rst_n(rst_i),
        .ce(ce),
        .run(scl_f & sda_f),
        .expired(idle_tmo)
    );

    // only an abandoned transaction counts; an already idle target ignores it
    assign tmo_any = (scl_low_tmo | idle_tmo) & (state_ff != SMBTP_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // target protocol
    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            state_ff <= SMBTP_IDLE;
            bit_cnt_ff <= `SMBTP_BIT_CNT_ZERO;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            rw_ff <= 1'b0;
            idx_done_ff <= 1'b0;
            wrote_ff <= 1'b0;
            drv_ff <= '{out: 1'b0, oe_n: 1'b1};
        end else if (ce) begin
            if (tmo_any) begin
                state_ff <= SMBTP_IDLE;
                drv_ff.oe_n <= 1'b1;
            end else if (start_det) begin
                state_ff <= SMBTP_ADDR;
                bit_cnt_ff <= `SMBTP_BIT_CNT_ZERO;
                drv_ff.oe_n <= 1'b1;
            end else if (stop_det) begin
                state_ff <= SMBTP_IDLE;
                drv_ff.oe_n <= 1'b1;
            end else begin
                case (state_ff)
                    SMBTP_ADDR: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_f};
                            bit_cnt_ff <= bit_cnt_ff + `SMBTP_BIT_CNT_ONE;
                        end else if (scl_fall && bit_cnt_ff == `SMBTP_BIT_CNT_FULL) begin
                            if (shift_ff[7:1] == `SMBTP_TARGET_ADDR) begin
                                rw_ff <= shift_ff[0];
                                drv_ff.oe_n <= 1'b0;
                                state_ff <= SMBTP_ADDR_ACK;
                            end else begin
                                // stay silent until the next start
                                state_ff <= SMBTP_IGNORE;
                            end
                        end
                    end
                    SMBTP_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rw_ff) begin
                                // read starts at the current pointer
                                drv_ff.oe_n <= reg_rdata[7];
                                tx_ff <= {reg_rdata[6:0], 1'b0};
                                bit_cnt_ff <= `SMBTP_BIT_CNT_ONE;
                                state_ff <= SMBTP_TX;
                            end else begin
                                drv_ff.oe_n <= 1'b1;
                                bit_cnt_ff <= `SMBTP_BIT_CNT_ZERO;
                                idx_done_ff <= 1'b0;
                                wrote_ff <= 1'b0;
                                state_ff <= SMBTP_RX;
                            end
                        end
                    end
                    SMBTP_RX: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_f};
                            bit_cnt_ff <= bit_cnt_ff + `SMBTP_BIT_CNT_ONE;
                        end else if (scl_fall && bit_cnt_ff == `SMBTP_BIT_CNT_FULL) begin
                            drv_ff.oe_n <= 1'b0;
                            state_ff <= SMBTP_RX_ACK;
                            if (!idx_done_ff) begin
                                idx_done_ff <= 1'b1;
                                wrote_ff <= 1'b0;
                            end else begin
                                wrote_ff <= 1'b1;
                            end
                        end
                    end
                    SMBTP_RX_ACK: begin
                        if (scl_fall) begin
                            drv_ff.oe_n <= 1'b1;
                            bit_cnt_ff <= `SMBTP_BIT_CNT_ZERO;
                            state_ff <= SMBTP_RX;
                            wrote_ff <= 1'b0;
                        end
                    end
                    SMBTP_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == `SMBTP_BIT_CNT_FULL) begin
                                // release for the host acknowledge
                                drv_ff.oe_n <= 1'b1;
                                state_ff <= SMBTP_TX_ACK;
                            end else begin
                                drv_ff.oe_n <= tx_ff[7];
                                tx_ff <= {tx_ff[6:0], 1'b0};
                                bit_cnt_ff <= bit_cnt_ff + `SMBTP_BIT_CNT_ONE;
                            end
                        end
                    end
                    SMBTP_TX_ACK: begin
                        if (scl_rise) begin
                            if (!sda_f) begin
                                state_ff <= SMBTP_ADDR_ACK;
                            end else begin
                                state_ff <= SMBTP_IGNORE;
                            end
                        end
                    end
                    SMBTP_IGNORE: begin
                        drv_ff.oe_n <= 1'b1;
                    end
                    default: begin
                        drv_ff.oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register pointer and write strobe; same priority as the protocol
    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            req_ff <= '{wr: 1'b0, addr: `SMBTP_PTR_RESET, wdata: 8'h00};
        end else if (ce) begin
            req_ff.wr <= 1'b0;
            if (!tmo_any && !start_det && !stop_det) begin
                case (state_ff)
                    SMBTP_RX: begin
                        if (scl_fall && bit_cnt_ff == `SMBTP_BIT_CNT_FULL) begin
                            if (!idx_done_ff) begin
                                // index byte only moves the pointer
                                req_ff.addr <= shift_ff;
                            end else begin
                                // later bytes are data, no count
                                req_ff.wr <= 1'b1;
                                req_ff.wdata <= shift_ff;
                            end
                        end
                    end
                    SMBTP_RX_ACK: begin
                        if (scl_fall && wrote_ff) begin
                            // step after the write, wraps at ff
                            req_ff.addr <= req_ff.addr + `SMBTP_PTR_STEP;
                        end
                    end
                    SMBTP_TX_ACK: begin
                        if (scl_rise && !sda_f) begin
                            // acked: next register, wraps at ff
                            req_ff.addr <= req_ff.addr + `SMBTP_PTR_STEP;
                        end
                    end
                    default: begin
                        req_ff.wr <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status
    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            busy_ff <= 1'b0;
        end else if (ce) begin
            busy_ff <= (state_ff != SMBTP_IDLE) && (state_ff != SMBTP_IGNORE);
        end
    end

    // one-cycle pulse: the state leaves the non-idle set on the same edge
    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            timeout_hit_ff <= 1'b0;
        end else if (ce) begin
            timeout_hit_ff <= tmo_any;
        end
    end

    assign sda_out = drv_ff.out;
    assign sda_oe_n = drv_ff.oe_n;
    assign busy = busy_ff;
    assign timeout_hit = timeout_hit_ff;
    assign reg_req = req_ff;

endmodule

// ==== smbtp_monitor.sv ====
// smbtp_monitor.sv: protocol checks on the two-wire target port
// assumes: bound to smbtp_target; pins reach the core through a 3-flop sync
`timescale 1ns/100ps
module smbtp_monitor #(
    parameter int SCL_LOW_CYCLES = 200,
    parameter int IDLE_CYCLES = 100
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // bus pins
    input wire logic bus_clock_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // configuration and status
    input wire logic timeout_en,
    input wire logic busy,
    input wire logic timeout_hit,
    // register space
    input wire smbtp_pkg::smbtp_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import smbtp_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] wr_addr_ff;
    int low_cnt_ff;
    int high_cnt_ff;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr_ff <= 8'h00;
        end else if (reg_req.wr) begin
            wr_addr_ff <= reg_req.addr;
        end
    end
    // raw pins lead the core by the sync delay, hence the slack in the bounds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_ff <= 0;
            high_cnt_ff <= 0;
        end else if (ce) begin
            low_cnt_ff <= (busy && timeout_en && !bus_clock_pin) ? low_cnt_ff + 1 : 0;
            high_cnt_ff <= (busy && bus_clock_pin && sda_in) ? high_cnt_ff + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence seq_stop;
        // clock already high one sample earlier: a bit driven just before a rise is no stop
        busy && bus_clock_pin && $past(bus_clock_pin) && $rose(sda_in);
    endsequence
    sequence seq_wr_taken;
        reg_req.wr;
    endsequence
    AST_STOP_IDLE: assert property (seq_stop |-> ##[1:10] !busy)
        else $error("busy held after stop");
    AST_WR_ONCE: assert property (seq_wr_taken |=> !reg_req.wr [*8])
        else $error("write strobe not a lone pulse");
    AST_WR_ACK: assert property (seq_wr_taken |-> busy ##[0:2] !sda_oe_n)
        else $error("stored byte not acknowledged");
    AST_PTR_STEP: assert property (seq_wr_taken |=> ##[0:40] reg_req.addr == wr_addr_ff + 8'h01)
        else $error("pointer did not step after write");
    AST_PTR_KEEP: assert property (!busy |=> $stable(reg_req.addr))
        else $error("pointer moved outside a transaction");
    AST_HIT_PULSE: assert property (timeout_hit |=> !timeout_hit && !busy && sda_oe_n)
        else $error("timeout did not release the port");
    AST_LOW_BOUND: assert property (low_cnt_ff <= SCL_LOW_CYCLES + 12)
        else $error("clock-low timeout late");
    AST_IDLE_BOUND: assert property (high_cnt_ff <= IDLE_CYCLES + 12)
        else $error("bus-idle reset late");
    AST_HIT_CAUSE: assert property (timeout_hit && !timeout_en |-> $past(bus_clock_pin, 5) && $past(sda_in, 5))
        else $error("clock-low timeout while disabled");
    AST_DRIVE_OWN: assert property (!sda_oe_n |-> busy || $past(busy))
        else $error("data driven outside own transaction");
    AST_OUT_LOW: assert property (!sda_oe_n |-> !sda_out)
        else $error("driven data level not low");
endmodule

bind smbtp_target smbtp_monitor #(
    .SCL_LOW_CYCLES(SCL_LOW_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)
) i_monitor (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus_clock_pin(bus_clock_pin), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .timeout_en(timeout_en), .busy(busy),
    .timeout_hit(timeout_hit), .reg_req(reg_req), .reg_rdata(reg_rdata)
);

// ==== smbtp_host_model.sv ====
// smbtp_host_model.sv: behavioural bus host driving clock and data
// assumes: data line resolved outside with a pull-up; moves on falling clk
`timescale 1ns/100ps
module smbtp_host_model (
    // clock
    input wire logic clk,
    // bus
    input wire logic sda_line,
    output logic scl,
    output logic pull
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // 5 low 3 high: 320 ns period
    // low phase longer so the target's answer lands before the rise
    task automatic bitx(input logic b, output logic s);
        pull = !b;
        repeat (3) @(negedge clk);
        scl = 1'b1;
        repeat (3) @(negedge clk);
        s = sda_line;
        scl = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic bus_start();
        pull = 1'b0;
        repeat (4) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        pull = 1'b1;
        repeat (4) @(negedge clk);
        scl = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic bus_stop();
        pull = 1'b1;
        repeat (4) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        pull = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], s);
        end
        bitx(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(last, s);
    endtask
    task automatic idle_high(input int n);
        pull = 1'b0;
        repeat (3) @(negedge clk);
        scl = 1'b1;
        repeat (n) @(negedge clk);
    endtask
endmodule

// ==== tb.sv ====
// tb.sv: self-checking bench for the two-wire register target port
// assumes: host model drives the pins; bench holds the register space
`timescale 1ns/100ps
module tb;
    import smbtp_pkg::*;
    logic clk;
    logic rst_n;
    logic timeout_en;
    logic ce;
    logic scl;
    logic pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe_n;
    logic busy;
    logic timeout_hit;
    smbtp_reg_req_t reg_req;
    logic [7:0] regs [256];
    logic [7:0] exp_regs [256];
    int mismatches;
    int tests_run;
    int hits;
    logic ack;
    logic [7:0] d;
    // pull-up on the data line
    assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & !pull;
    smbtp_target #(.SCL_LOW_CYCLES(200), .IDLE_CYCLES(100)) i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .bus_clock_pin(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .timeout_en(timeout_en), .busy(busy),
        .timeout_hit(timeout_hit), .reg_req(reg_req), .reg_rdata(regs[reg_req.addr]));
    smbtp_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .pull(pull));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (reg_req.wr === 1'b1) begin
            regs[reg_req.addr] <= reg_req.wdata;
        end
        if (timeout_hit === 1'b1) begin
            hits <= hits + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic open(input logic [7:0] a, input logic want);
        i_host.bus_start();
        i_host.put_byte(a, ack);
        check({7'h00, ack}, {7'h00, want});
    endtask
    task automatic put(input logic [7:0] b);
        i_host.put_byte(b, ack);
        check({7'h00, ack}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_write_byte();
        open(8'h50, 1'b1);
        put(8'h10);
        put(8'ha5);
        i_host.bus_stop();
        exp_regs[8'h10] = 8'ha5;
        check(regs[8'h10], exp_regs[8'h10]);
        check({7'h00, busy}, 8'h00);
    endtask
    task automatic t_block_write();
        open(8'h50, 1'b1);
        put(8'hfe);
        for (int i = 0; i < 3; i++) begin
            put(8'(8'h11 * (i + 1)));
            exp_regs[8'(8'hfe + i)] = 8'(8'h11 * (i + 1));
        end
        i_host.bus_stop();
        // fourth slot lies past the wrap and must stay untouched
        for (int i = 0; i < 4; i++) begin
            check(regs[8'(8'hfe + i)], exp_regs[8'(8'hfe + i)]);
        end
    endtask
    task automatic t_read(input logic [7:0] idx, input int n);
        open(8'h50, 1'b1);
        put(idx);
        open(8'h51, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_host.get_byte(i == n - 1, d);
            check(d, exp_regs[8'(idx + i)]);
        end
        i_host.bus_stop();
    endtask
    task automatic t_send_receive();
        open(8'h50, 1'b1);
        put(8'h40);
        i_host.bus_stop();
        check(regs[8'h40], exp_regs[8'h40]);
        repeat (2) begin
            open(8'h51, 1'b1);
            i_host.get_byte(1'b1, d);
            i_host.bus_stop();
            check(d, exp_regs[8'h40]);
        end
    endtask
    task automatic t_wrong_addr(input logic [7:0] a);
        open(a, 1'b0);
        i_host.put_byte(8'h10, ack);
        check({7'h00, ack}, 8'h00);
        i_host.put_byte(8'h77, ack);
        i_host.bus_stop();
        check(regs[8'h10], exp_regs[8'h10]);
    endtask
    task automatic t_timeouts();
        open(8'h50, 1'b1);
        repeat (260) @(negedge clk);
        check(hits[7:0], 8'h00);
        check({7'h00, busy}, 8'h01);
        timeout_en = 1'b1;
        // a frozen port must not count the low clock
        ce = 1'b0;
        repeat (260) @(negedge clk);
        check(hits[7:0], 8'h00);
        check({7'h00, busy}, 8'h01);
        ce = 1'b1;
        repeat (260) @(negedge clk);
        check(hits[7:0], 8'h01);
        check({7'h00, busy}, 8'h00);
        // idle reset must work with the clock-low timeout off
        timeout_en = 1'b0;
        i_host.bus_stop();
        open(8'h50, 1'b1);
        i_host.idle_high(160);
        check(hits[7:0], 8'h02);
        check({7'h00, busy}, 8'h00);
        t_write_byte();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        timeout_en = 1'b0;
        ce = 1'b1;
        for (int i = 0; i < 256; i++) begin
            regs[i] = i[7:0] ^ 8'h3c;
            exp_regs[i] = i[7:0] ^ 8'h3c;
        end
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        t_write_byte();
        t_block_write();
        t_read(8'h10, 1);
        t_read(8'hfe, 3);
        t_send_receive();
        t_wrong_addr(8'h52);
        t_wrong_addr(8'hd0);
        t_timeouts();
        give_verdict();
    end
    // about 3900 cycles expected; generous margin
    initial begin
        #1000000;
        mismatches++;
        give_verdict();
    end
endmodule
